/* design/vifc_top.sv */
// Interrupt flag controller top: request and mask flags, edge detection
// for two pins, fixed priority vectoring, standby release, reset vector.
// Assumes all inputs are synchronous to REF_CLK_IN and the core pulses
// VECT_ACK_IN for one cycle while VECT_REQ_OUT is high.
`timescale 1ns/100ps
`default_nettype none

module vifc_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic [15:0] REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic        REG_BIT_EN_IN,
  input  wire logic [2:0]  REG_BIT_SEL_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  input  wire logic        LOW_VOLTAGE_DET_IN,
  input  wire logic        LOW_VOLTAGE_ACTION_SEL_IN,
  input  wire logic        PIN_ZERO_IN,
  input  wire logic        PIN_ONE_IN,
  input  wire logic        BYTE_TIMER_MATCH_IN,
  input  wire logic        TIMER_CH0_MATCH_IN,
  input  wire logic        TIMER_CH1_MATCH_IN,
  input  wire logic        TIMER_CH0_CAPTURE_MODE_IN,
  input  wire logic        TIMER_CH1_CAPTURE_MODE_IN,
  input  wire logic        CAPTURE_PIN_ZERO_IN,
  input  wire logic        CAPTURE_PIN_ONE_IN,
  input  wire logic [1:0]  CAPTURE_EDGE_SEL_IN,
  input  wire logic        CONVERSION_DONE_IN,
  input  wire logic        EXT_RESET_IN,
  input  wire logic        POWER_ON_CLEAR_IN,
  input  wire logic        WATCHDOG_OVERFLOW_IN,
  input  wire logic        GLOBAL_IRQ_ENABLE_IN,
  input  wire logic        VECT_ACK_IN,
  output logic             VECT_REQ_OUT,
  output logic      [15:0] VECTOR_ADDR_OUT,
  output logic             STANDBY_RELEASE_OUT,
  output logic             SYS_RESET_REQ_OUT,
  output logic      [3:0]  RESET_CAUSE_OUT,
  output logic      [15:0] RESET_VECTOR_OUT,
  output logic             OVERRUN_IRQ_OUT
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [7:0] req_flags;
  logic [7:0] mask_flags;
  logic [7:0] edge_sel;
  logic [7:0] ovr_status;
  logic [7:0] ovr_mask;
  logic       pin_zero_prev;
  logic       pin_one_prev;
  logic       cap_zero_prev;
  logic       cap_one_prev;
  logic [2:0] sel_idx;

  // -----------------------------------------------------------------------
  // Combinational terms
  // -----------------------------------------------------------------------
  logic [7:0] hw_events;
  logic [7:0] wr_bits;
  logic [7:0] wr_value;
  logic       wr_req;
  logic       wr_mask;
  logic       wr_edge;
  logic       wr_ovr_status;
  logic       wr_ovr_mask;
  logic       flag_access;
  logic       ack_taken;
  logic [7:0] ack_clear;
  logic [7:0] eligible;
  logic [2:0] winner;
  logic       has_winner;
  logic [7:0] next_req_flags;
  logic [7:0] next_mask_flags;
  logic [3:0] next_cause;

  // Edge detector: fall, rise or both per two-bit select
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    unique case (sel)
      vifc_pkg::EDGE_FALL: edge_hit = fall;
      vifc_pkg::EDGE_RISE: edge_hit = rise;
      vifc_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default:             edge_hit = 1'b0;
    endcase
  endfunction

  // Address decode and write lane forming for bit or byte access
  always_comb begin
    wr_req        = REG_WR_IN && (REG_ADDR_IN == vifc_pkg::ADDR_REQ_FLAGS);
    wr_mask       = REG_WR_IN && (REG_ADDR_IN == vifc_pkg::ADDR_MASK_FLAGS);
    wr_edge       = REG_WR_IN && (REG_ADDR_IN == vifc_pkg::ADDR_EDGE_SEL);
    wr_ovr_status = REG_WR_IN && (REG_ADDR_IN == vifc_pkg::ADDR_OVR_STATUS);
    wr_ovr_mask   = REG_WR_IN && (REG_ADDR_IN == vifc_pkg::ADDR_OVR_MASK);
    flag_access   = (REG_WR_IN || REG_RD_IN) &&
                    ((REG_ADDR_IN == vifc_pkg::ADDR_REQ_FLAGS) ||
                     (REG_ADDR_IN == vifc_pkg::ADDR_MASK_FLAGS));
    if (REG_BIT_EN_IN) begin
      wr_bits  = 8'h01 << REG_BIT_SEL_IN;
      wr_value = {8{REG_WDATA_IN[0]}} & wr_bits;
    end else begin
      wr_bits  = 8'hFF;
      wr_value = REG_WDATA_IN;
    end
  end

  // Hardware request events of the seven sources
  always_comb begin
    hw_events = 8'h00;
    // Low-voltage raises the interrupt only in interrupt mode
    hw_events[vifc_pkg::BIT_LOW_VOLTAGE] = LOW_VOLTAGE_DET_IN &
                                           ~LOW_VOLTAGE_ACTION_SEL_IN;
    // Pin edges; a level driven onto a shared pin counts too
    hw_events[vifc_pkg::BIT_PIN_ZERO] =
      edge_hit(edge_sel[vifc_pkg::ES_PIN_ZERO_LO +: 2], pin_zero_prev,
               PIN_ZERO_IN);
    hw_events[vifc_pkg::BIT_PIN_ONE] =
      edge_hit(edge_sel[vifc_pkg::ES_PIN_ONE_LO +: 2], pin_one_prev,
               PIN_ONE_IN);
    hw_events[vifc_pkg::BIT_BYTE_TIMER] = BYTE_TIMER_MATCH_IN;
    // Channel zero captures on pin one, channel one on pin zero
    hw_events[vifc_pkg::BIT_TIMER_CH0] = TIMER_CH0_CAPTURE_MODE_IN ?
      edge_hit(CAPTURE_EDGE_SEL_IN, cap_one_prev, CAPTURE_PIN_ONE_IN) :
      TIMER_CH0_MATCH_IN;
    hw_events[vifc_pkg::BIT_TIMER_CH1] = TIMER_CH1_CAPTURE_MODE_IN ?
      edge_hit(CAPTURE_EDGE_SEL_IN, cap_zero_prev, CAPTURE_PIN_ZERO_IN) :
      TIMER_CH1_MATCH_IN;
    hw_events[vifc_pkg::BIT_CONVERSION] = CONVERSION_DONE_IN;
  end

  // Fixed priority pick among unmasked pending requests
  always_comb begin
    eligible   = req_flags & ~mask_flags & vifc_pkg::FLAG_BITS_USED;
    winner     = 3'h0;
    has_winner = 1'b0;
    for (int i = vifc_pkg::PRIO_LOWEST; i >= vifc_pkg::PRIO_HIGHEST; i--) begin
      if (eligible[i]) begin
        winner     = 3'(i);
        has_winner = 1'b1;
      end
    end
  end

  // Acknowledge of the presented vector clears its flag
  always_comb begin
    ack_taken = VECT_ACK_IN && VECT_REQ_OUT;
    ack_clear = 8'h00;
    if (ack_taken) begin
      ack_clear = 8'h01 << sel_idx;
    end
  end

  // Next request flags: write, then acknowledge clear, then hardware set
  always_comb begin
    next_req_flags = req_flags;
    if (wr_req) begin
      next_req_flags = (req_flags & ~wr_bits) | (wr_value & wr_bits);
    end
    next_req_flags = (next_req_flags & ~ack_clear) | hw_events;
    next_req_flags = next_req_flags & vifc_pkg::FLAG_BITS_USED;
  end

  // Next mask flags with bit 0 held at one
  always_comb begin
    next_mask_flags = mask_flags;
    if (wr_mask) begin
      next_mask_flags = (mask_flags & ~wr_bits) | (wr_value & wr_bits);
    end
    next_mask_flags = next_mask_flags | ~vifc_pkg::FLAG_BITS_USED;
  end

  // Reset causes that share the reset vector
  always_comb begin
    next_cause = 4'h0;
    next_cause[vifc_pkg::CAUSE_EXTERNAL] = EXT_RESET_IN;
    next_cause[vifc_pkg::CAUSE_POWER_ON] = POWER_ON_CLEAR_IN;
    next_cause[vifc_pkg::CAUSE_LOW_VOLT] = LOW_VOLTAGE_DET_IN &
                                           LOW_VOLTAGE_ACTION_SEL_IN;
    next_cause[vifc_pkg::CAUSE_WATCHDOG] = WATCHDOG_OVERFLOW_IN;
  end

  // -----------------------------------------------------------------------
  // Flag registers
  // -----------------------------------------------------------------------

  // Request flags
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      req_flags <= vifc_pkg::RST_REQ_FLAGS;
    end else begin
      req_flags <= next_req_flags;
    end
  end

  // Mask flags, all masked after reset
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mask_flags <= vifc_pkg::RST_MASK_FLAGS;
    end else begin
      mask_flags <= next_mask_flags;
    end
  end

  // Pin edge select, byte writes only, unused bits kept zero
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      edge_sel <= vifc_pkg::RST_EDGE_SEL;
    end else if (wr_edge && !REG_BIT_EN_IN) begin
      edge_sel <= REG_WDATA_IN & vifc_pkg::EDGE_SEL_USED;
    end
  end

  // Previous levels for edge detection
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pin_zero_prev <= 1'b0;
      pin_one_prev  <= 1'b0;
      cap_zero_prev <= 1'b0;
      cap_one_prev  <= 1'b0;
    end else begin
      pin_zero_prev <= PIN_ZERO_IN;
      pin_one_prev  <= PIN_ONE_IN;
      cap_zero_prev <= CAPTURE_PIN_ZERO_IN;
      cap_one_prev  <= CAPTURE_PIN_ONE_IN;
    end
  end

  // -----------------------------------------------------------------------
  // Overrun events: a request arriving while its flag is already set
  // -----------------------------------------------------------------------

  // Sticky status, write one to clear, new event wins
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ovr_status <= vifc_pkg::RST_OVR_STATUS;
    end else if (wr_ovr_status) begin
      ovr_status <= (ovr_status & ~(wr_value & wr_bits)) | (hw_events & req_flags);
    end else begin
      ovr_status <= ovr_status | (hw_events & req_flags);
    end
  end

  // Overrun mask, one masks
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ovr_mask <= vifc_pkg::RST_OVR_MASK;
    end else if (wr_ovr_mask) begin
      ovr_mask <= (ovr_mask & ~wr_bits) | (wr_value & wr_bits);
    end
  end

  // Overrun interrupt level
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      OVERRUN_IRQ_OUT <= 1'b0;
    end else begin
      OVERRUN_IRQ_OUT <= |(ovr_status & ~ovr_mask);
    end
  end

  // -----------------------------------------------------------------------
  // Read port
  // -----------------------------------------------------------------------

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        vifc_pkg::ADDR_REQ_FLAGS:  REG_RDATA_OUT <= req_flags;
        vifc_pkg::ADDR_MASK_FLAGS: REG_RDATA_OUT <= mask_flags;
        vifc_pkg::ADDR_EDGE_SEL:   REG_RDATA_OUT <= edge_sel;
        vifc_pkg::ADDR_OVR_STATUS: REG_RDATA_OUT <= ovr_status;
        vifc_pkg::ADDR_OVR_MASK:   REG_RDATA_OUT <= ovr_mask;
        default:                   REG_RDATA_OUT <= 8'h00;
      endcase
    end else begin
      REG_RDATA_OUT <= 8'h00;
    end
  end

  // -----------------------------------------------------------------------
  // Vectoring to the core
  // -----------------------------------------------------------------------

  // Request only with global enable, held off during flag access
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      VECT_REQ_OUT <= 1'b0;
    end else begin
      VECT_REQ_OUT <= has_winner && GLOBAL_IRQ_ENABLE_IN &&
                      !flag_access && !ack_taken;
    end
  end

  // Presented vector and the source it belongs to
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      VECTOR_ADDR_OUT <= vifc_pkg::VECTOR_TABLE[0];
      sel_idx         <= 3'h0;
    end else if (!ack_taken) begin
      VECTOR_ADDR_OUT <= vifc_pkg::VECTOR_TABLE[winner];
      sel_idx         <= winner;
    end
  end

  // Standby release on any pending request, masked or not
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      STANDBY_RELEASE_OUT <= 1'b0;
    end else begin
      STANDBY_RELEASE_OUT <= |req_flags;
    end
  end

  // -----------------------------------------------------------------------
  // Reset request and shared reset vector
  // -----------------------------------------------------------------------

  // Reset request and cause, cause held until the next reset event
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SYS_RESET_REQ_OUT <= 1'b0;
      RESET_CAUSE_OUT   <= 4'h0;
    end else begin
      SYS_RESET_REQ_OUT <= |next_cause;
      if (|next_cause) begin
        RESET_CAUSE_OUT <= next_cause;
      end
    end
  end

  // Reset vector for every reset cause
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RESET_VECTOR_OUT <= vifc_pkg::RESET_VECTOR;
    end else begin
      RESET_VECTOR_OUT <= vifc_pkg::RESET_VECTOR;
    end
  end

endmodule

`default_nettype wire

/* design/vifc_pkg.sv */
// Constants for the vectored interrupt flag controller: register map, reset
// values, field positions, vector table and reset vector.
// Assumes a byte-wide register port and a core that owns the status word.
//
// What this block does
// - Fixed priority, level 1 highest, 7 lowest.
// - Fixed vector address per maskable source.
// - Reset fetches start address at 0000H/0001H.
// - Four reset causes share one reset vector.
// - Low-voltage: interrupt if select 0, reset if 1.
// - Timer channels: compare match or opposite capture edge.
// - Source request or software write sets flag.
// - Acknowledge, software or reset clears flag.
// - Request flags at FFE0H, reset 00H, bit0 zero.
// - Flags and masks accept bit and byte access.
// - Masks at FFE4H, reset FFH, bit0 one.
// - Mask 0 allows servicing, flag still sets.
// - Any request releases standby, vectoring when acknowledgeable.
// - Present selected vector; core jumps through it.
// - Driving a shared pin sets its flag.
// - Vectoring only while global enable is one.
// - Core saves status, PC, clears enable.
// - Edge select: 00 fall, 01 rise, 11 both.
package vifc_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [15:0] ADDR_REQ_FLAGS   = 16'hFFE0;
  localparam logic [15:0] ADDR_MASK_FLAGS  = 16'hFFE4;
  localparam logic [15:0] ADDR_EDGE_SEL    = 16'hFFEC;
  localparam logic [15:0] ADDR_OVR_STATUS  = 16'hFFE8;
  localparam logic [15:0] ADDR_OVR_MASK    = 16'hFFE9;

  localparam logic [7:0]  RST_REQ_FLAGS    = 8'h00;
  localparam logic [7:0]  RST_MASK_FLAGS   = 8'hFF;
  localparam logic [7:0]  RST_EDGE_SEL     = 8'h00;
  localparam logic [7:0]  RST_OVR_STATUS   = 8'h00;
  localparam logic [7:0]  RST_OVR_MASK     = 8'hFF;
  localparam logic [7:0]  EDGE_SEL_USED    = 8'h3C;
  localparam logic [7:0]  FLAG_BITS_USED   = 8'hFE;

  // ---------------------------------------------------------------------
  // Source bit positions, also the priority level
  // ---------------------------------------------------------------------
  localparam int BIT_LOW_VOLTAGE  = 1;
  localparam int BIT_PIN_ZERO     = 2;
  localparam int BIT_PIN_ONE      = 3;
  localparam int BIT_BYTE_TIMER   = 4;
  localparam int BIT_TIMER_CH0    = 5;
  localparam int BIT_TIMER_CH1    = 6;
  localparam int BIT_CONVERSION   = 7;
  localparam int PRIO_HIGHEST     = 1;
  localparam int PRIO_LOWEST      = 7;

  // Edge select field positions and codes
  localparam int          ES_PIN_ZERO_LO = 2;
  localparam int          ES_PIN_ONE_LO  = 4;
  localparam logic [1:0]  EDGE_FALL      = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;

  // ---------------------------------------------------------------------
  // Vector table, indexed by source bit
  // ---------------------------------------------------------------------
  localparam logic [15:0] VECTOR_TABLE [0:7] = '{
    16'h0000, 16'h0006, 16'h0008, 16'h000A,
    16'h000C, 16'h000E, 16'h0010, 16'h0012
  };
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;

  // Reset cause bits
  localparam int CAUSE_EXTERNAL  = 0;
  localparam int CAUSE_POWER_ON  = 1;
  localparam int CAUSE_LOW_VOLT  = 2;
  localparam int CAUSE_WATCHDOG  = 3;

endpackage

/* verif/vifc_sva.sv */
// Checker for the interrupt flag controller, watching the top ports only.
// Assumes one clock REF_CLK_IN and active-low NRST_IN; bound from the bench.
`timescale 1ns/100ps
`default_nettype none

module vifc_sva (
  input wire logic        REF_CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        REG_RD_IN,
  input wire logic [7:0]  REG_RDATA_OUT,
  input wire logic        GLOBAL_IRQ_ENABLE_IN,
  input wire logic        VECT_ACK_IN,
  input wire logic        VECT_REQ_OUT,
  input wire logic [15:0] VECTOR_ADDR_OUT,
  input wire logic        CONVERSION_DONE_IN,
  input wire logic        STANDBY_RELEASE_OUT,
  input wire logic        EXT_RESET_IN,
  input wire logic        WATCHDOG_OVERFLOW_IN,
  input wire logic        LOW_VOLTAGE_DET_IN,
  input wire logic        LOW_VOLTAGE_ACTION_SEL_IN,
  input wire logic        SYS_RESET_REQ_OUT,
  input wire logic [3:0]  RESET_CAUSE_OUT,
  input wire logic [15:0] RESET_VECTOR_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  // ---------------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------------
  rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data not idle");
  req_needs_en_a: assert property ($rose(VECT_REQ_OUT) |-> $past(GLOBAL_IRQ_ENABLE_IN))
    else $error("request raised without enable");
  ack_drops_req_a: assert property (VECT_ACK_IN && VECT_REQ_OUT |=> !VECT_REQ_OUT)
    else $error("request held after acknowledge");
  vector_table_a: assert property (VECT_REQ_OUT |-> VECTOR_ADDR_OUT inside
    {16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0012})
    else $error("vector outside table");
  standby_event_a: assert property (CONVERSION_DONE_IN |-> ##2 STANDBY_RELEASE_OUT)
    else $error("no standby release");
  ext_reset_a: assert property (EXT_RESET_IN |=> SYS_RESET_REQ_OUT && RESET_CAUSE_OUT[0])
    else $error("external reset not reported");
  watchdog_rst_a: assert property (WATCHDOG_OVERFLOW_IN
    |=> SYS_RESET_REQ_OUT && RESET_CAUSE_OUT[3])
    else $error("watchdog reset not reported");
  lv_reset_a: assert property (LOW_VOLTAGE_DET_IN && LOW_VOLTAGE_ACTION_SEL_IN
    |=> SYS_RESET_REQ_OUT && RESET_CAUSE_OUT[2])
    else $error("low-voltage reset not reported");
  reset_vector_a: assert property (RESET_VECTOR_OUT == 16'h0000)
    else $error("reset vector wrong");
endmodule

`default_nettype wire

/* verif/vifc_core_model.sv */
// Processor core model: holds the enable flag and acknowledges requests.
// Assumes the controller keeps its request up until acknowledged.
`timescale 1ns/100ps
`default_nettype none

module vifc_core_model (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic req_in,
  input  wire logic ei_in,
  input  wire logic slow_in,
  output logic      ack_out,
  output logic      irq_en_out
);
  logic [1:0] wait_cnt;

  // ---------------------------------------------------------------------
  // Acknowledge after 0 or 2 waiting cycles, then drop the enable
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {ack_out, irq_en_out, wait_cnt} <= 4'h0;
    end else if (ack_out) begin
      {ack_out, irq_en_out, wait_cnt} <= 4'h0;
    end else if (req_in && irq_en_out && wait_cnt >= {slow_in, 1'b0}) begin
      ack_out <= 1'b1;
    end else begin
      wait_cnt <= req_in ? wait_cnt + 2'd1 : 2'd0;
      irq_en_out <= irq_en_out | ei_in;
    end
  end
endmodule

`default_nettype wire

/* verif/vectored_interrupt_flag_controller_tb_top.sv */
// Bench for the interrupt flag controller: table of sources, then priority,
// enable, bit access, overlap, edge select and reset causes.
// Assumes vifc_top, vifc_sva and vifc_core_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module vectored_interrupt_flag_controller_tb_top;
  logic        REF_CLK_IN = 1'b0, NRST_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0;
  logic        REG_BIT_EN_IN = 1'b0, LOW_VOLTAGE_ACTION_SEL_IN = 1'b0, ei = 1'b0, slow = 1'b0;
  logic        TIMER_CH0_CAPTURE_MODE_IN = 1'b0, TIMER_CH1_CAPTURE_MODE_IN = 1'b0;
  logic        CAPTURE_PIN_ZERO_IN = 1'b0, CAPTURE_PIN_ONE_IN = 1'b0;
  logic [15:0] REG_ADDR_IN = 16'h0000, VECTOR_ADDR_OUT, RESET_VECTOR_OUT;
  logic [7:0]  REG_WDATA_IN = 8'h00, REG_RDATA_OUT;
  logic [2:0]  REG_BIT_SEL_IN = 3'h0;
  logic [1:0]  CAPTURE_EDGE_SEL_IN = 2'h0;
  logic [7:1]  src = 7'h00;
  logic [3:0]  cause = 4'h0, RESET_CAUSE_OUT;
  logic        GLOBAL_IRQ_ENABLE_IN, VECT_ACK_IN, VECT_REQ_OUT;
  logic        STANDBY_RELEASE_OUT, SYS_RESET_REQ_OUT, OVERRUN_IRQ_OUT;
  int          err_count = 0, comparisons = 0;
  // Source pulse (flag byte) beside the vector it should produce
  localparam logic [23:0] ROWS [1:7] = '{24'h020006, 24'h040008, 24'h08000A, 24'h10000C,
                                         24'h20000E, 24'h400010, 24'h800012};
  localparam logic [3:0]  RISE = 4'b1010;
  localparam logic [3:0]  FALL = 4'b1001;

  always #5 REF_CLK_IN = ~REF_CLK_IN;

  vifc_top u_dut (
    .LOW_VOLTAGE_DET_IN   (src[1] | cause[2]),
    .PIN_ZERO_IN          (src[2]),
    .PIN_ONE_IN           (src[3]),
    .BYTE_TIMER_MATCH_IN  (src[4]),
    .TIMER_CH0_MATCH_IN   (src[5]),
    .TIMER_CH1_MATCH_IN   (src[6]),
    .CONVERSION_DONE_IN   (src[7]),
    .EXT_RESET_IN         (cause[0]),
    .POWER_ON_CLEAR_IN    (cause[1]),
    .WATCHDOG_OVERFLOW_IN (cause[3]),
    .*
  );

  vifc_core_model u_core (
    .clk_in  (REF_CLK_IN),
    .nrst_in (NRST_IN),
    .req_in  (VECT_REQ_OUT),
    .ei_in   (ei),
    .slow_in (slow),
    .ack_out (VECT_ACK_IN),
    .irq_en_out (GLOBAL_IRQ_ENABLE_IN)
  );

  // ---------------------------------------------------------------------
  // Bus, event and core tasks
  // ---------------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic be = 1'b0,
                    input logic [2:0] sel = 3'h0);
    @(posedge REF_CLK_IN);
    {REG_WR_IN, REG_BIT_EN_IN, REG_ADDR_IN, REG_WDATA_IN, REG_BIT_SEL_IN} <= {1'b1, be, a, d, sel};
    @(posedge REF_CLK_IN);
    {REG_WR_IN, REG_BIT_EN_IN} <= 2'b00;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge REF_CLK_IN);
    {REG_RD_IN, REG_ADDR_IN} <= {1'b1, a};
    @(posedge REF_CLK_IN);
    REG_RD_IN <= 1'b0;
    @(negedge REF_CLK_IN);
    `CHK(REG_RDATA_OUT, e)
  endtask

  task automatic pulse(input logic [7:1] m);
    @(posedge REF_CLK_IN) src <= src ^ m;
    @(posedge REF_CLK_IN) src <= src ^ m;
  endtask

  task automatic enable();
    @(posedge REF_CLK_IN) ei <= 1'b1;
    @(posedge REF_CLK_IN) ei <= 1'b0;
  endtask

  task automatic serve(input logic [15:0] e);
    int n = 0;
    while (VECT_ACK_IN !== 1'b1 && n < 40) begin
      @(negedge REF_CLK_IN);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      results();
    end else `CHK(VECTOR_ADDR_OUT, e)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge REF_CLK_IN);
    NRST_IN <= 1'b1;
    rd(16'hFFE0, 8'h00);
    rd(16'hFFE4, 8'hFF);
    rd(16'hFFF0, 8'h00);
    `CHK(RESET_VECTOR_OUT, 16'h0000)
    wr(16'hFFEC, 8'h3C);
    for (int i = 1; i <= 7; i++) begin
      pulse(ROWS[i][23:17]);
      rd(16'hFFE0, ROWS[i][23:16]);
      `CHK(STANDBY_RELEASE_OUT, 1'b1)
      wr(16'hFFE4, ~ROWS[i][23:16]);
      enable();
      serve(ROWS[i][15:0]);
      rd(16'hFFE0, 8'h00);
      wr(16'hFFE4, 8'hFF);
    end
    pulse(7'h4C);
    rd(16'hFFE0, 8'h98);
    enable();
    repeat (4) @(negedge REF_CLK_IN) `CHK(VECT_REQ_OUT, 1'b0)
    @(posedge REF_CLK_IN) slow <= 1'b1;
    wr(16'hFFE4, 8'h00);
    serve(16'h000A);
    repeat (4) @(negedge REF_CLK_IN) `CHK(VECT_REQ_OUT, 1'b0)
    enable();
    serve(16'h000C);
    enable();
    serve(16'h0012);
    wr(16'hFFE0, 8'h01, 1'b1, 3'h4);
    rd(16'hFFE0, 8'h10);
    wr(16'hFFE0, 8'hFF);
    rd(16'hFFE0, 8'hFE);
    wr(16'hFFE0, 8'h00, 1'b1, 3'h1);
    rd(16'hFFE0, 8'hFC);
    rd(16'hFFE4, 8'h01);
    wr(16'hFFE4, 8'hFF);
    wr(16'hFFE4, 8'h00, 1'b1, 3'h6);
    rd(16'hFFE4, 8'hBF);
    wr(16'hFFE4, 8'hFF);
    @(posedge REF_CLK_IN);
    {REG_WR_IN, REG_ADDR_IN, REG_WDATA_IN, src} <= {1'b1, 16'hFFE0, 8'h00, 7'h40};
    @(posedge REF_CLK_IN);
    {REG_WR_IN, src} <= {1'b0, 7'h00};
    rd(16'hFFE0, 8'h80);
    wr(16'hFFE0, 8'h00);
    {TIMER_CH0_CAPTURE_MODE_IN, CAPTURE_EDGE_SEL_IN} <= 3'b101;
    pulse(7'h10);
    rd(16'hFFE0, 8'h00);
    @(posedge REF_CLK_IN) CAPTURE_PIN_ONE_IN <= 1'b1;
    rd(16'hFFE0, 8'h20);
    // Channel one captures on pin zero, falling edge only
    @(posedge REF_CLK_IN) {TIMER_CH1_CAPTURE_MODE_IN, CAPTURE_EDGE_SEL_IN} <= 3'b100;
    @(posedge REF_CLK_IN) CAPTURE_PIN_ZERO_IN <= 1'b1;
    rd(16'hFFE0, 8'h20);
    @(posedge REF_CLK_IN) CAPTURE_PIN_ZERO_IN <= 1'b0;
    rd(16'hFFE0, 8'h60);
    for (int c = 0; c < 4; c++) begin
      wr(16'hFFEC, 8'(c << 4));
      wr(16'hFFE0, 8'h00);
      src[3] <= 1'b1;
      rd(16'hFFE0, {4'h0, RISE[c], 3'h0});
      wr(16'hFFE0, 8'h00);
      src[3] <= 1'b0;
      rd(16'hFFE0, {4'h0, FALL[c], 3'h0});
    end
    // Second request while the flag stands: overrun status and level
    wr(16'hFFE8, 8'hFF);
    wr(16'hFFE9, 8'h7F);
    pulse(7'h40);
    pulse(7'h40);
    rd(16'hFFE8, 8'h80);
    `CHK(OVERRUN_IRQ_OUT, 1'b1)
    wr(16'hFFE8, 8'h80);
    rd(16'hFFE8, 8'h00);
    `CHK(OVERRUN_IRQ_OUT, 1'b0)
    wr(16'hFFE0, 8'h00);
    LOW_VOLTAGE_ACTION_SEL_IN <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge REF_CLK_IN) cause <= 4'(1 << k);
      @(posedge REF_CLK_IN) cause <= 4'h0;
      @(negedge REF_CLK_IN) `CHK(SYS_RESET_REQ_OUT, 1'b1)
      `CHK(RESET_CAUSE_OUT, 4'(1 << k))
    end
    rd(16'hFFE0, 8'h00);
    results();
  end
endmodule

bind vifc_top vifc_sva u_sva (.*);

`undef CHK
`default_nettype wire
